//--- common/frbg_map.vh
// Constants for the fractional baud generator pair: register indices,
// field positions, reset values and sampling-mode codes.
// Assumes inclusion by bare name from the design files.
//
// Notes on behaviour
// - There are two independent generators, transmit and receive, each with its own prescaler and divisor set.
// - Bit 7 of the modem control register makes both prescalers divide the reference by 4 when set, by 1 when clear.
// - Each generator divides the prescaled clock by a divisor from 1 to 65536 minus 1/16 in steps of 1/16.
// - The output is a sampling pulse at 16, 8 or 4 times the serial rate for shifting and sampling.
// - Reset leaves each divisor at exactly one: low byte 0x01, high byte and fraction register 0x00.
// - The integer divisor is the high byte above the low byte.
// - The low four fraction bits add 0 to 15/16 to the divisor in linear sixteenths.
// - Fraction register bits 5:4 pick 16X (00), 8X (01) or 4X (10) sampling.
// - In 8X mode with an odd non-zero fraction a bit time may jitter by up to 1/16.
// - Register access works with the reference clock stopped and never waits on it.
// - A serial bit lasts 16, 8 or 4 sampling periods according to the mode.
`ifndef FRBG_MAP_VH
`define FRBG_MAP_VH

// ==========================================================
// Register indices on the 3-bit host address
`define FRBG_IDX_TX_LOW 3'h0
`define FRBG_IDX_TX_HIGH 3'h1
`define FRBG_IDX_TX_FRAC 3'h2
`define FRBG_IDX_RX_LOW 3'h3
`define FRBG_IDX_RX_HIGH 3'h4
`define FRBG_IDX_RX_FRAC 3'h5
`define FRBG_IDX_MODEM_CTRL 3'h6

// ==========================================================
// Reset values
`define FRBG_RST_LOW 8'h01
`define FRBG_RST_HIGH 8'h00
`define FRBG_RST_FRAC 8'h00
`define FRBG_RST_MODEM_CTRL 8'h00

// ==========================================================
// Field positions
`define FRBG_MCR_PRESCALE_BIT 7
`define FRBG_FRAC_MSB 3
`define FRBG_FRAC_LSB 0
`define FRBG_MODE_MSB 5
`define FRBG_MODE_LSB 4
`define FRBG_FRAC_REG_MASK 8'h3f

// ==========================================================
// Sampling modes and periods per bit
`define FRBG_MODE_16X 2'h0
`define FRBG_MODE_8X 2'h1
`define FRBG_MODE_4X 2'h2
`define FRBG_BIT_16X 5'h10
`define FRBG_BIT_8X 5'h08
`define FRBG_BIT_4X 5'h04
`define FRBG_PRESCALE_LAST 2'h3

`endif

//--- design/frbg_divider.v
// One baud generator: prescaler, fractional divisor and bit-period counter.
// Assumes the reference input is a level already synchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
`include "frbg_map.vh"

module frbg_divider (
   input wire core_clk,
   input wire reset,
   input wire osc_clock_input,
   input wire prescale_by4,
   input wire [15:0] divisor_int,
   input wire [3:0] divisor_frac,
   input wire [1:0] sample_mode,
   output reg sample_tick_q,
   output reg bit_tick_q
);

   reg osc_prev_q;
   reg [1:0] pre_cnt_q;
   reg [16:0] cnt_q;
   reg [3:0] acc_q;
   reg [4:0] bit_cnt_q;
   wire osc_rise;
   wire pre_tick;
   wire [4:0] acc_sum;
   wire [16:0] period;
   wire [17:0] cnt_next;
   wire wrap;
   reg [4:0] bit_len;

   // ==========================================================
   // Prescaler
   assign osc_rise = osc_clock_input & ~osc_prev_q;
   assign pre_tick = osc_rise & (~prescale_by4 | (pre_cnt_q == `FRBG_PRESCALE_LAST));

   always @(posedge core_clk) begin
      if (reset) begin
         osc_prev_q <= 1'b0;
         pre_cnt_q <= 2'h0;
      end else begin
         osc_prev_q <= osc_clock_input;
         if (osc_rise) begin
            pre_cnt_q <= pre_cnt_q + 2'h1;
         end
      end
   end

   // ==========================================================
   // Fractional divisor
   // Carry of the fraction accumulator stretches one period by a cycle
   // Same spread in every mode, so 8X with an odd fraction shows a sixteenth of bit jitter
   assign acc_sum = {1'b0, acc_q} + {1'b0, divisor_frac};
   // A zero integer part is held at one, the least divisor
   assign period = {1'b0, (divisor_int == 16'h0000) ? 16'h0001 : divisor_int} + {16'h0000, acc_sum[4]};
   assign cnt_next = {1'b0, cnt_q} + 18'h00001;
   // Compare with >= so a smaller divisor written mid-count cannot overrun
   assign wrap = (cnt_next >= {1'b0, period});

   always @(posedge core_clk) begin
      if (reset) begin
         cnt_q <= 17'h00000;
         acc_q <= 4'h0;
         sample_tick_q <= 1'b0;
      end else begin
         sample_tick_q <= pre_tick & wrap;
         if (pre_tick) begin
            if (wrap) begin
               cnt_q <= 17'h00000;
               acc_q <= acc_sum[3:0];
            end else begin
               cnt_q <= cnt_next[16:0];
            end
         end
      end
   end

   // ==========================================================
   // Sampling periods per serial bit; reserved mode 11 acts as 16X
   always @* begin
      case (sample_mode)
         `FRBG_MODE_8X: bit_len = `FRBG_BIT_8X;
         `FRBG_MODE_4X: bit_len = `FRBG_BIT_4X;
         default: bit_len = `FRBG_BIT_16X;
      endcase
   end

   // Bit boundary pulse in the same cycle as every bit_len-th sampling pulse
   always @(posedge core_clk) begin
      if (reset) begin
         bit_cnt_q <= 5'h00;
         bit_tick_q <= 1'b0;
      end else begin
         bit_tick_q <= 1'b0;
         if (pre_tick & wrap) begin
            if (bit_cnt_q + 5'h01 >= bit_len) begin
               bit_cnt_q <= 5'h00;
               bit_tick_q <= 1'b1;
            end else begin
               bit_cnt_q <= bit_cnt_q + 5'h01;
            end
         end
      end
   end

endmodule // frbg_divider
`default_nettype wire

//--- design/frbg_top.v
// Register file and the transmit and receive baud generators.
// Assumes a host strobe port synchronous to core_clk and a sampled reference level.
`timescale 1ns/1ps
`default_nettype none
`include "frbg_map.vh"

module frbg_top (
   input wire core_clk,
   input wire reset,
   input wire osc_clock_input,
   input wire reg_cs,
   input wire reg_wr,
   input wire reg_rd,
   input wire [2:0] reg_addr,
   input wire [7:0] reg_wdata,
   output reg [7:0] reg_rdata_q,
   output wire tx_sample_tick,
   output wire tx_bit_tick,
   output wire rx_sample_tick,
   output wire rx_bit_tick
);

   reg [7:0] tx_low_q;
   reg [7:0] tx_high_q;
   reg [7:0] tx_frac_q;
   reg [7:0] rx_low_q;
   reg [7:0] rx_high_q;
   reg [7:0] rx_frac_q;
   reg [7:0] modem_control_reg_q;
   wire wr_en;
   wire rd_en;

   // Fraction register keeps only its defined bits
   function [7:0] frac_field;
      input [7:0] value;
      begin
         frac_field = value & `FRBG_FRAC_REG_MASK;
      end
   endfunction

   // ==========================================================
   // Host port; runs on core_clk only, never on the reference
   assign wr_en = reg_cs & reg_wr;
   assign rd_en = reg_cs & reg_rd;

   // Register writes
   always @(posedge core_clk) begin
      if (reset) begin
         tx_low_q <= `FRBG_RST_LOW;
         tx_high_q <= `FRBG_RST_HIGH;
         tx_frac_q <= `FRBG_RST_FRAC;
         rx_low_q <= `FRBG_RST_LOW;
         rx_high_q <= `FRBG_RST_HIGH;
         rx_frac_q <= `FRBG_RST_FRAC;
         modem_control_reg_q <= `FRBG_RST_MODEM_CTRL;
      end else if (wr_en) begin
         case (reg_addr)
            `FRBG_IDX_TX_LOW: tx_low_q <= reg_wdata;
            `FRBG_IDX_TX_HIGH: tx_high_q <= reg_wdata;
            `FRBG_IDX_TX_FRAC: tx_frac_q <= frac_field(reg_wdata);
            `FRBG_IDX_RX_LOW: rx_low_q <= reg_wdata;
            `FRBG_IDX_RX_HIGH: rx_high_q <= reg_wdata;
            `FRBG_IDX_RX_FRAC: rx_frac_q <= frac_field(reg_wdata);
            `FRBG_IDX_MODEM_CTRL: modem_control_reg_q <= reg_wdata;
            default: ;
         endcase
      end
   end

   // Registered read data, unmapped index reads zero
   always @(posedge core_clk) begin
      if (reset) begin
         reg_rdata_q <= 8'h00;
      end else if (rd_en) begin
         case (reg_addr)
            `FRBG_IDX_TX_LOW: reg_rdata_q <= tx_low_q;
            `FRBG_IDX_TX_HIGH: reg_rdata_q <= tx_high_q;
            `FRBG_IDX_TX_FRAC: reg_rdata_q <= tx_frac_q;
            `FRBG_IDX_RX_LOW: reg_rdata_q <= rx_low_q;
            `FRBG_IDX_RX_HIGH: reg_rdata_q <= rx_high_q;
            `FRBG_IDX_RX_FRAC: reg_rdata_q <= rx_frac_q;
            `FRBG_IDX_MODEM_CTRL: reg_rdata_q <= modem_control_reg_q;
            default: reg_rdata_q <= 8'h00;
         endcase
      end
   end

   // ==========================================================
   // Two independent generators sharing the prescale select
   frbg_divider u_tx_gen (
      .core_clk(core_clk),
      .reset(reset),
      .osc_clock_input(osc_clock_input),
      .prescale_by4(modem_control_reg_q[`FRBG_MCR_PRESCALE_BIT]),
      .divisor_int({tx_high_q, tx_low_q}),
      .divisor_frac(tx_frac_q[`FRBG_FRAC_MSB:`FRBG_FRAC_LSB]),
      .sample_mode(tx_frac_q[`FRBG_MODE_MSB:`FRBG_MODE_LSB]),
      .sample_tick_q(tx_sample_tick),
      .bit_tick_q(tx_bit_tick)
   );

   frbg_divider u_rx_gen (
      .core_clk(core_clk),
      .reset(reset),
      .osc_clock_input(osc_clock_input),
      .prescale_by4(modem_control_reg_q[`FRBG_MCR_PRESCALE_BIT]),
      .divisor_int({rx_high_q, rx_low_q}),
      .divisor_frac(rx_frac_q[`FRBG_FRAC_MSB:`FRBG_FRAC_LSB]),
      .sample_mode(rx_frac_q[`FRBG_MODE_MSB:`FRBG_MODE_LSB]),
      .sample_tick_q(rx_sample_tick),
      .bit_tick_q(rx_bit_tick)
   );

endmodule // frbg_top
`default_nettype wire

//--- sim/frbg_top_chk.sv
// Checker for the baud generator pair.
// Assumes a bind onto frbg_top by port name.
`timescale 1ns/1ps
`default_nettype none
module frbg_top_chk (
   input wire core_clk,
   input wire reset,
   input wire osc_clock_input,
   input wire reg_cs,
   input wire reg_wr,
   input wire reg_rd,
   input wire [2:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire [7:0] reg_rdata_q,
   input wire tx_sample_tick,
   input wire tx_bit_tick,
   input wire rx_sample_tick,
   input wire rx_bit_tick
);
   // ==========================
   // Tick shape and host port
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   AST_TX_BIT: assert property (tx_bit_tick |-> tx_sample_tick)
      else $error("tx bit tick alone");
   AST_RX_BIT: assert property (rx_bit_tick |-> rx_sample_tick)
      else $error("rx bit tick alone");
   AST_TX_PULSE: assert property (tx_sample_tick |=> !tx_sample_tick)
      else $error("tx tick too long");
   AST_RX_PULSE: assert property (rx_sample_tick |=> !rx_sample_tick)
      else $error("rx tick too long");
   AST_BIT_GAP: assert property (tx_bit_tick |=> !tx_bit_tick [*7])
      else $error("tx bit ticks too close");
   AST_NO_REF: assert property ((!osc_clock_input) [*4] |-> !tx_sample_tick && !rx_sample_tick)
      else $error("tick without reference");
   AST_RD_HOLD: assert property (!(reg_cs && reg_rd) |=> $stable(reg_rdata_q))
      else $error("read data moved");
   AST_FRAC_TOP: assert property (reg_cs && reg_rd && (reg_addr == 3'h2 || reg_addr == 3'h5)
      |=> reg_rdata_q[7:6] == 2'b00)
      else $error("fraction top bits set");
endmodule // frbg_top_chk

bind frbg_top frbg_top_chk chk_u (.core_clk, .reset, .osc_clock_input, .reg_cs, .reg_wr, .reg_rd,
   .reg_addr, .reg_wdata, .reg_rdata_q, .tx_sample_tick, .tx_bit_tick, .rx_sample_tick, .rx_bit_tick);
`default_nettype wire

//--- sim/tb_frbg_top.sv
// Testbench for the baud generator pair.
// Assumes frbg_top and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_frbg_top;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic osc_clock_input = 1'b0;
   logic osc_run = 1'b0;
   logic reg_cs = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   wire [7:0] reg_rdata_q;
   wire tx_sample_tick, tx_bit_tick, rx_sample_tick, rx_bit_tick;
   int fail_count = 0;
   int checks = 0;
   logic [7:0] rst_tbl [0:7] = '{8'h01, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};

   frbg_top dut_u (.core_clk, .reset, .osc_clock_input, .reg_cs, .reg_wr, .reg_rd, .reg_addr,
      .reg_wdata, .reg_rdata_q, .tx_sample_tick, .tx_bit_tick, .rx_sample_tick, .rx_bit_tick);

   // ==========================
   // Clocks
   always #5 core_clk = ~core_clk;
   // Reference: one core cycle high, one low
   always @(negedge core_clk) osc_clock_input <= osc_run ? ~osc_clock_input : 1'b0;

   // ==========================
   // Tasks
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task end_sim;
      if (fail_count == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // Host cycles, strobes set and dropped at falling edges
   task wr(input logic [2:0] a, input logic [7:0] d);
      @(negedge core_clk);
      reg_cs = 1'b1;
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge core_clk);
      reg_cs = 1'b0;
      reg_wr = 1'b0;
   endtask

   task rd(input logic [2:0] a, input logic [7:0] e);
      @(negedge core_clk);
      reg_cs = 1'b1;
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge core_clk);
      reg_cs = 1'b0;
      reg_rd = 1'b0;
      chk({8'h00, reg_rdata_q}, {8'h00, e});
   endtask

   // Program one generator, sync on a bit tick, time 16 sample periods
   task run(input logic s, input logic [7:0] lo, hi, fr, mc, input int ce, be);
      int c;
      int n;
      int b;
      wr(s ? 3'h3 : 3'h0, lo);
      wr(s ? 3'h4 : 3'h1, hi);
      wr(s ? 3'h5 : 3'h2, fr);
      wr(3'h6, mc);
      c = 0;
      n = 0;
      b = 0;
      while ((s ? rx_bit_tick : tx_bit_tick) !== 1'b1 && c < 20000) begin
         @(posedge core_clk);
         #1;
         c++;
      end
      c = 0;
      while (n < 16 && c < 20000) begin
         @(posedge core_clk);
         #1;
         c++;
         if ((s ? rx_sample_tick : tx_sample_tick) === 1'b1) n++;
         if ((s ? rx_bit_tick : tx_bit_tick) === 1'b1) b++;
      end
      chk(c[15:0], ce[15:0]);
      chk(b[15:0], be[15:0]);
   endtask

   // ==========================
   // Main sequence
   initial begin
      repeat (10) @(negedge core_clk);
      reset = 1'b0;
      for (int i = 0; i < 8; i++) rd(i[2:0], rst_tbl[i]);
      wr(3'h7, 8'h5a);
      rd(3'h7, 8'h00);
      wr(3'h1, 8'ha6);
      wr(3'h2, 8'hff);
      rd(3'h1, 8'ha6);
      rd(3'h2, 8'h3f);
      rd(3'h4, 8'h00);
      osc_run = 1'b1;
      run(1'b0, 8'h02, 8'h00, 8'h08, 8'h00, 80, 1);
      run(1'b1, 8'h03, 8'h00, 8'h10, 8'h00, 96, 2);
      run(1'b0, 8'h01, 8'h00, 8'h2f, 8'h80, 248, 4);
      run(1'b1, 8'h00, 8'h01, 8'h00, 8'h00, 8192, 1);
      run(1'b0, 8'h02, 8'h00, 8'h11, 8'h00, 66, 2);
      run(1'b1, 8'h00, 8'h00, 8'h30, 8'h00, 32, 1);
      end_sim;
   end

   // Watchdog well past the longest expected run
   initial begin
      #600000;
      fail_count++;
      end_sim;
   end
endmodule // tb_frbg_top
`default_nettype wire
